// >>> core/tlic_defs.vh
`ifndef TLIC_DEFS_VH
`define TLIC_DEFS_VH
`define TLIC_VEC_HIGH 16'h0008
`define TLIC_VEC_LOW 16'h0018
`define TLIC_CTRL_GH_BIT 7
`define TLIC_CTRL_GL_BIT 6
`define TLIC_RST_PSE_BIT 7
`define TLIC_LAT_MIN 2'h3
`define TLIC_LAT_MAX 3'h4
`define TLIC_ST_IDLE 3'h1
`define TLIC_ST_SYNC 3'h2
`define TLIC_ST_VEC 3'h4
`endif

// >>> core/tlic_top.v
// Overview of operation
// RQ1 - Priority mode sends high requests to 0008h and low requests to 0018h.
// RQ2 - An enabled high request preempts a running low service routine.
// RQ3 - Every source has a flag, an enable and a priority select.
// RQ4 - Two-level operation only while the priority scheme enable bit is set.
// RQ5 - Priority mode: control bit 7 gates high sources, bit 6 low sources.
// RQ6 - Flag, enable and matching global enable set makes the device vector.
// RQ7 - Scheme enable resets cleared; then priority bits do not affect routing.
// RQ8 - Compatibility mode: bit 6 gates peripherals, bit 7 gates everything.
// RQ9 - Compatibility mode sends every accepted interrupt to 0008h.
// RQ10 - Accepting an interrupt clears the global enable that admitted it.
// RQ11 - No low request is accepted while a high routine runs.
// RQ12 - Acceptance pushes the return address and loads the vector.
// RQ13 - Software polls flags and clears them before re-enabling.
// RQ14 - Return from service leaves the routine and sets the enable again.
// RQ15 - External events are answered within three to four instruction cycles.
// RQ16 - Flags set on their event whatever the enables say.
// RQ17 - Software avoids memory moves on control registers while enabled.
// RQ18 - External pins have an edge select: set rising, cleared falling.
// RQ19 - A flagged enabled source wakes the core regardless of global enables.
// RQ20 - Simultaneous high and low requests: high first, low stays pending.
`include "tlic_defs.vh"
module tlic_top #(
  parameter N_SRC = 8,
  parameter N_EXT = 4,
  parameter PC_W = 16
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire instr_cycle_i,
  input wire [N_SRC-1:0] src_event_i,
  input wire [N_SRC-1:0] src_is_periph_i,
  input wire [N_EXT-1:0] ext_pin_i,
  input wire [N_EXT-1:0] ext0_edge_select_i,
  input wire [N_SRC-1:0] src_enable_i,
  input wire [N_SRC-1:0] src_high_prio_i,
  input wire [N_SRC-1:0] flag_clear_i,
  input wire [N_SRC-1:0] flag_set_i,
  input wire priority_scheme_enable_i,
  input wire pse_write_i,
  input wire [7:0] ctrl_wdata_i,
  input wire ctrl_write_i,
  input wire return_from_service_i,
  input wire [PC_W-1:0] return_addr_i,
  output reg [N_SRC-1:0] src_flag_o,
  output reg priority_scheme_enable_o,
  output reg high_level_global_enable_o,
  output reg low_level_global_enable_o,
  output reg vector_load_o,
  output reg [PC_W-1:0] vector_addr_o,
  output reg stack_push_o,
  output reg [PC_W-1:0] stack_push_data_o,
  output reg in_high_service_o,
  output reg in_low_service_o,
  output reg wake_o
);
  // The flags below are the external pins first; the rest are internal sources.
  reg [N_EXT-1:0] pin_q;
  reg [N_EXT-1:0] ext_edge;
  reg [2:0] state;
  reg [2:0] lat_cnt;
  reg take_high;
  reg take_low;
  reg [N_SRC-1:0] next_flag;
  wire [N_SRC-1:0] armed;
  wire [N_SRC-1:0] hi_src;
  wire [N_SRC-1:0] lo_src;
  wire req_high;
  wire req_low;
  wire pse;
  wire gh;
  wire gl;
  genvar g;

  wire in_idle;
  wire in_vec;
  wire ret_take;
  wire ret_high;
  wire ret_low;
  wire accept_high;
  wire accept_low;
  wire lat_done;

  // Picks the armed sources of one level in priority mode; both request paths use it.
  function [N_SRC-1:0] level_sources;
    input [N_SRC-1:0] act;
    input [N_SRC-1:0] prio;
    input want_high;
    begin
      level_sources = want_high ? (act & prio) : (act & ~prio);
    end
  endfunction

  assign pse = priority_scheme_enable_o;
  assign gh = high_level_global_enable_o;
  assign gl = low_level_global_enable_o;
  assign armed = src_flag_o & src_enable_i; // RQ3
  // Compatibility mode routes everything as high level; the low path only exists in priority mode.
  assign hi_src = pse ? level_sources(armed, src_high_prio_i, 1'b1) : (armed & (~src_is_periph_i | {N_SRC{gl}})); // RQ7 RQ8
  assign lo_src = pse ? level_sources(armed, src_high_prio_i, 1'b0) : {N_SRC{1'b0}}; // RQ4
  assign req_high = gh && (|hi_src); // RQ5 RQ6
  assign req_low = pse && gl && (|lo_src) && !in_high_service_o; // RQ5 RQ11

  assign in_idle = (state == `TLIC_ST_IDLE);
  assign in_vec = (state == `TLIC_ST_VEC);
  // A return is only taken while nothing is being accepted, so it never races an entry.
  assign ret_take = in_idle && !req_high && !req_low && return_from_service_i; // RQ14
  // Return closes the innermost routine and reopens its gate.
  assign ret_high = ret_take && (in_high_service_o || !pse);
  assign ret_low = ret_take && !ret_high && in_low_service_o;
  assign accept_high = in_vec && take_high;
  assign accept_low = in_vec && !take_high;
  assign lat_done = instr_cycle_i && (lat_cnt == ({1'b0, `TLIC_LAT_MIN} - 3'h1)); // RQ15

  generate
    for (g = 0; g < N_EXT; g = g + 1) begin : g_edge
      always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          pin_q[g] <= 1'b0;
        end else begin
          pin_q[g] <= ext_pin_i[g];
        end
      end
      always @* begin
        ext_edge[g] = ext0_edge_select_i[g] ? (ext_pin_i[g] & ~pin_q[g]) : (~ext_pin_i[g] & pin_q[g]); // RQ18
      end
    end
  endgenerate

  always @* begin
    next_flag = (src_flag_o & ~flag_clear_i) | src_event_i | flag_set_i; // RQ16
    next_flag[N_EXT-1:0] = next_flag[N_EXT-1:0] | ext_edge;
  end

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      src_flag_o <= {N_SRC{1'b0}};
    end else begin
      src_flag_o <= next_flag;
    end
  end

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= |armed; // RQ19
    end
  end

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      priority_scheme_enable_o <= 1'b0; // RQ7
    end else if (pse_write_i) begin
      priority_scheme_enable_o <= priority_scheme_enable_i; // RQ4
    end
  end

  // An acceptance outranks a software write in the same cycle.
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      high_level_global_enable_o <= 1'b0;
    end else if (accept_high) begin
      high_level_global_enable_o <= 1'b0; // RQ10
    end else if (ret_high) begin
      high_level_global_enable_o <= 1'b1; // RQ14
    end else if (ctrl_write_i) begin
      high_level_global_enable_o <= ctrl_wdata_i[`TLIC_CTRL_GH_BIT];
    end
  end

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      low_level_global_enable_o <= 1'b0;
    end else if (accept_low) begin
      low_level_global_enable_o <= 1'b0; // RQ10
    end else if (ret_low) begin
      low_level_global_enable_o <= 1'b1; // RQ14
    end else if (ctrl_write_i) begin
      low_level_global_enable_o <= ctrl_wdata_i[`TLIC_CTRL_GL_BIT];
    end
  end

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      in_high_service_o <= 1'b0;
    end else if (accept_high) begin
      in_high_service_o <= 1'b1;
    end else if (ret_high) begin
      in_high_service_o <= 1'b0;
    end
  end

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      in_low_service_o <= 1'b0;
    end else if (accept_low) begin
      in_low_service_o <= 1'b1;
    end else if (ret_low) begin
      in_low_service_o <= 1'b0;
    end
  end

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      vector_load_o <= 1'b0;
      stack_push_o <= 1'b0;
    end else begin
      vector_load_o <= in_vec; // RQ12
      stack_push_o <= in_vec;
    end
  end

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      vector_addr_o <= {PC_W{1'b0}};
    end else if (accept_high) begin
      vector_addr_o <= `TLIC_VEC_HIGH; // RQ1 RQ9
    end else if (accept_low) begin
      vector_addr_o <= `TLIC_VEC_LOW; // RQ1
    end
  end

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stack_push_data_o <= {PC_W{1'b0}};
    end else if (in_vec) begin
      stack_push_data_o <= return_addr_i; // RQ12
    end
  end

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= `TLIC_ST_IDLE;
      lat_cnt <= 3'h0;
    end else begin
      case (state)
        `TLIC_ST_IDLE: begin
          if (req_high || req_low) begin
            lat_cnt <= 3'h0;
            state <= `TLIC_ST_SYNC;
          end
        end
        `TLIC_ST_SYNC: begin
          if (instr_cycle_i) begin
            lat_cnt <= lat_cnt + 3'h1;
          end
          if (lat_done) begin
            state <= `TLIC_ST_VEC;
          end
        end
        `TLIC_ST_VEC: begin
          state <= `TLIC_ST_IDLE;
        end
        default: begin
          state <= `TLIC_ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      take_high <= 1'b0;
      take_low <= 1'b0;
    end else begin
      case (state)
        `TLIC_ST_IDLE: begin
          if (req_high) begin // RQ20
            take_high <= 1'b1;
            take_low <= 1'b0;
          end else if (req_low) begin
            take_high <= 1'b0;
            take_low <= 1'b1;
          end
        end
        `TLIC_ST_SYNC: begin
          // A pending low acceptance is upgraded if a high request appears meanwhile.
          if (take_low && req_high) begin // RQ2
            take_high <= 1'b1;
            take_low <= 1'b0;
          end
        end
        default: begin
          take_high <= 1'b0;
          take_low <= 1'b0;
        end
      endcase
    end
  end
endmodule // tlic_top

// >>> tb/tlic_properties.sv
module tlic_properties #(
  parameter N_SRC = 8,
  parameter PC_W = 16
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [N_SRC-1:0] src_event_i,
  input wire [N_SRC-1:0] src_flag_o,
  input wire priority_scheme_enable_o,
  input wire high_level_global_enable_o,
  input wire vector_load_o,
  input wire stack_push_o,
  input wire [PC_W-1:0] vector_addr_o,
  input wire in_high_service_o,
  input wire in_low_service_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  push_with_load_a: assert property (vector_load_o |-> stack_push_o) else $error("no push");
  load_one_cycle_a: assert property (vector_load_o |=> !vector_load_o) else $error("long load");
  compat_vector_a: assert property (vector_load_o && !priority_scheme_enable_o |-> vector_addr_o == 16'h0008)
    else $error("compat vector");
  low_vector_a: assert property ($rose(in_low_service_o) |-> vector_load_o && vector_addr_o == 16'h0018)
    else $error("low vector");
  high_clear_a: assert property (vector_load_o && vector_addr_o == 16'h0008 |-> !high_level_global_enable_o)
    else $error("enable kept");
  flag_set_a: assert property ((|src_event_i) |=> (src_flag_o & $past(src_event_i)) == $past(src_event_i))
    else $error("flag lost");
  no_low_in_high_a: assert property ($rose(in_low_service_o) |-> !$past(in_high_service_o))
    else $error("low in high");
  preempt_high_a: assert property (vector_load_o && $past(in_low_service_o) |-> vector_addr_o == 16'h0008)
    else $error("bad preempt");
endmodule // tlic_properties

// >>> tb/tlic_cpu_model.sv
module tlic_cpu_model (
  input wire logic clk_i,
  input wire logic [7:0] svc_len_i,
  input wire logic [7:0] src_flag_o,
  input wire logic [7:0] src_high_prio_i,
  input wire logic priority_scheme_enable_o,
  input wire logic in_high_service_o,
  input wire logic in_low_service_o,
  output logic [7:0] flag_clear_i = 8'h00,
  output logic return_from_service_i = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Serves the innermost level: clears only the high-priority flags in a high routine under the priority scheme, otherwise all flags, then returns.
  always @(negedge clk_i) begin
    if ((in_high_service_o | in_low_service_o) === 1'b1) begin
      repeat (svc_len_i) @(negedge clk_i);
      flag_clear_i = src_flag_o & (in_high_service_o & priority_scheme_enable_o ? src_high_prio_i : 8'hff);
      @(negedge clk_i);
      flag_clear_i = 8'h00;
      return_from_service_i = 1'b1;
      @(negedge clk_i);
      return_from_service_i = 1'b0;
    end
  end
endmodule // tlic_cpu_model

// >>> tb/test_two_level_interrupt_controller.sv
module test_two_level_interrupt_controller;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, sys_rst_i = 1, instr_cycle_i = 1, pse_write_i = 0, ctrl_write_i = 0;
  logic priority_scheme_enable_i = 0, return_from_service_i, vector_load_o, stack_push_o, wake_o;
  logic [7:0] src_event_i = 0, src_is_periph_i = 8'hf0, src_enable_i = 8'hff, src_high_prio_i = 0;
  logic [7:0] flag_clear_i, flag_set_i = 0, ctrl_wdata_i = 0, svc_len_i = 2, src_flag_o;
  logic [3:0] ext_pin_i = 0, ext0_edge_select_i = 1;
  logic [15:0] return_addr_i = 16'h1234, vector_addr_o, stack_push_data_o, exp_q[$];
  logic priority_scheme_enable_o, high_level_global_enable_o, low_level_global_enable_o;
  logic in_high_service_o, in_low_service_o;
  int num_errors = 0, checked = 0, cycles = 0, seed = 41296, n, k;
  tlic_top i_tlic_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .instr_cycle_i(instr_cycle_i),
    .src_event_i(src_event_i), .src_is_periph_i(src_is_periph_i), .ext_pin_i(ext_pin_i),
    .ext0_edge_select_i(ext0_edge_select_i), .src_enable_i(src_enable_i), .src_high_prio_i(src_high_prio_i),
    .flag_clear_i(flag_clear_i), .flag_set_i(flag_set_i), .priority_scheme_enable_i(priority_scheme_enable_i),
    .pse_write_i(pse_write_i), .ctrl_wdata_i(ctrl_wdata_i), .ctrl_write_i(ctrl_write_i),
    .return_from_service_i(return_from_service_i), .return_addr_i(return_addr_i), .src_flag_o(src_flag_o),
    .priority_scheme_enable_o(priority_scheme_enable_o), .high_level_global_enable_o(high_level_global_enable_o),
    .low_level_global_enable_o(low_level_global_enable_o), .vector_load_o(vector_load_o),
    .vector_addr_o(vector_addr_o), .stack_push_o(stack_push_o), .stack_push_data_o(stack_push_data_o),
    .in_high_service_o(in_high_service_o), .in_low_service_o(in_low_service_o), .wake_o(wake_o));
  tlic_cpu_model i_tlic_cpu_model (.clk_i(clk_i), .svc_len_i(svc_len_i), .src_flag_o(src_flag_o),
    .src_high_prio_i(src_high_prio_i), .priority_scheme_enable_o(priority_scheme_enable_o),
    .in_high_service_o(in_high_service_o), .in_low_service_o(in_low_service_o),
    .flag_clear_i(flag_clear_i), .return_from_service_i(return_from_service_i));
  always #5 clk_i = ~clk_i;
  task chk(input [15:0] got, input [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task setup(input pse, input [7:0] ctrl);
    @(negedge clk_i);
    {priority_scheme_enable_i, pse_write_i, ctrl_wdata_i, ctrl_write_i} = {pse, 1'b1, ctrl, 1'b1};
    @(negedge clk_i);
    {pse_write_i, ctrl_write_i} = 0;
  endtask
  task fire(input [7:0] ev);
    @(negedge clk_i);
    src_event_i = ev;
    @(negedge clk_i);
    src_event_i = 0;
    for (n = 1; n < 20 && vector_load_o !== 1; n++)
      @(negedge clk_i);
  endtask
  task idle;
    for (k = 0; k < 300 && (in_high_service_o | in_low_service_o | wake_o) !== 0; k++)
      @(negedge clk_i);
  endtask
  always @(negedge clk_i) begin
    if (vector_load_o === 1) begin
      chk(vector_addr_o, exp_q.size() ? exp_q.pop_front() : 16'hffff);
      chk({stack_push_o, stack_push_data_o}, 17'h11234);
    end
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      test_done;
    end
  end
  initial begin
    repeat (2) @(negedge clk_i);
    sys_rst_i = 0;
    chk({priority_scheme_enable_o, high_level_global_enable_o, low_level_global_enable_o}, 0);
    setup(0, 8'hc0);
    src_high_prio_i = $random(seed);
    exp_q.push_back(16'h0008);
    fire(8'h01 << ($random(seed) & 7));
    chk(n, 6);
    chk(high_level_global_enable_o, 0);
    idle;
    chk(high_level_global_enable_o, 1);
    $display("compat done");
    setup(1, 8'hc0);
    {src_high_prio_i, svc_len_i} = {8'h0f, 8'd60};
    exp_q.push_back(16'h0018);
    fire(8'h10);
    chk({n[3:0], high_level_global_enable_o, low_level_global_enable_o}, 16'h1a);
    exp_q.push_back(16'h0008);
    fire(8'h01);
    idle;
    chk({high_level_global_enable_o, low_level_global_enable_o}, 3);
    svc_len_i = 2;
    exp_q.push_back(16'h0008);
    exp_q.push_back(16'h0018);
    fire(8'h11);
    idle;
    $display("priority done");
    setup(1, 8'h00);
    src_enable_i = 0;
    ext_pin_i = 3;
    repeat (4) @(negedge clk_i);
    chk(src_flag_o, 1);
    ext_pin_i = 0;
    repeat (4) @(negedge clk_i);
    chk(src_flag_o, 3);
    src_enable_i = 2;
    repeat (3) @(negedge clk_i);
    chk(wake_o, 1);
    chk(exp_q.size(), 0);
    $display("pins done");
    test_done;
  end
endmodule // test_two_level_interrupt_controller
bind tlic_top tlic_properties #(.N_SRC(N_SRC), .PC_W(PC_W)) i_tlic_properties (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .src_event_i(src_event_i), .src_flag_o(src_flag_o), .priority_scheme_enable_o(priority_scheme_enable_o),
  .high_level_global_enable_o(high_level_global_enable_o), .vector_load_o(vector_load_o),
  .stack_push_o(stack_push_o), .vector_addr_o(vector_addr_o), .in_high_service_o(in_high_service_o),
  .in_low_service_o(in_low_service_o));
